// ### design/pds_pkg.sv
/*
 pds_pkg: constants and types for the pump deragging sequencer.
 assumes a single 100 MHz system clock and a fixed time base tick.
*/
package pds_pkg;
	// clock rate and time base
	localparam int unsigned CLOCK_HZ       = 100_000_000;
	localparam int unsigned TICK_MS        = 1;
	localparam int unsigned TICK_CYCLES    = (CLOCK_HZ / 1000) * TICK_MS;
	// widths
	localparam int unsigned CYCLE_W        = 8;
	localparam int unsigned TIME_W         = 16;
	localparam int unsigned SPEED_W        = 16;
	// extended status word
	localparam int unsigned EXT_STATUS_W   = 32;
	localparam int unsigned DERAG_BIT      = 23;
	localparam logic [31:0] DERAG_MASK     = 32'h0080_0000;
	// trigger selection for start and stop commands
	localparam logic [1:0]  SEL_OFF        = 2'h0;
	localparam logic [1:0]  SEL_START      = 2'h1;
	localparam logic [1:0]  SEL_STOP       = 2'h2;
	localparam logic [1:0]  SEL_BOTH       = 2'h3;
	// reset values
	localparam logic [15:0] SPEED_RESET    = 16'h0000;

	typedef enum logic [2:0] {
		PDS_IDLE     = 3'b000,
		PDS_RAMPDOWN = 3'b001,
		PDS_PREDELAY = 3'b010,
		PDS_REVERSE  = 3'b011,
		PDS_COAST    = 3'b100,
		PDS_FORWARD  = 3'b101
	} pds_state_type;
endpackage

// ### design/pds_tick.sv
/*
 pds_tick: free running time base, one pulse every TICKS clocks.
 assumes the sequencer clock and reset.
*/
`timescale 1ns/1ps
module pds_tick #(
	parameter int unsigned TICKS = pds_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic i_clock,
	input  wire logic i_rst_n,
	// time base
	output logic      o_tick
);
	localparam int unsigned CW = $clog2(TICKS + 1);
	localparam logic [CW-1:0] LAST = CW'(TICKS - 1);

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic          next_tick;

	always_comb begin
		next_count = count + CW'(1);
		next_tick  = 1'b0;
		if (count >= LAST) begin
			next_count = '0;
			next_tick  = 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count  <= '0;
			o_tick <= 1'b0;
		end else begin
			count  <= next_count;
			o_tick <= next_tick;
		end
	end
endmodule // pds_tick

// ### design/pds_sequencer.sv
/*
 pds_sequencer: pump deragging event sequencer.
 assumes the drive's speed control honours the run, reverse and speed commands,
 and reports standstill on i_motor_stopped; triggers are synchronous pulses.
*/
`timescale 1ns/1ps
module pds_sequencer #(
	parameter int unsigned CYCLE_W = pds_pkg::CYCLE_W,
	parameter int unsigned TIME_W  = pds_pkg::TIME_W,
	parameter int unsigned SPEED_W = pds_pkg::SPEED_W,
	parameter int unsigned TICKS   = pds_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic               i_clock,
	input  wire logic               i_rst_n,
	// configuration
	input  wire logic               i_enable,
	input  wire logic [1:0]         i_start_stop_select,
	input  wire logic [CYCLE_W-1:0] i_cycle_count,
	input  wire logic [TIME_W-1:0]  i_off_delay,
	input  wire logic [TIME_W-1:0]  i_run_time,
	input  wire logic [SPEED_W-1:0] i_derag_speed,
	input  wire logic               i_output_assigned,
	input  wire logic               i_power_trigger_enable,
	input  wire logic [SPEED_W-1:0] i_power_limit,
	// triggers
	input  wire logic               i_start_cmd,
	input  wire logic               i_stop_cmd,
	input  wire logic               i_digital_input,
	input  wire logic               i_sequence_logic_controller,
	input  wire logic               i_timed_action,
	input  wire logic [SPEED_W-1:0] i_power,
	// motor feedback
	input  wire logic               i_motor_stopped,
	// motor commands
	output logic                    o_override,
	output logic                    o_ramp_stop,
	output logic                    o_run,
	output logic                    o_reverse,
	output logic [SPEED_W-1:0]      o_speed,
	// status
	output logic                    o_active,
	output logic                    o_digital_output,
	output logic [31:0]             o_ext_status,
	output logic [CYCLE_W-1:0]      o_cycles_done
);
	localparam int unsigned STATUS_W = pds_pkg::EXT_STATUS_W;

	// time base
	logic                   tick;

	// trigger group
	logic                   over_limit;
	logic                   next_over_limit;
	logic                   power_rise;
	logic                   command_hit;
	logic                   trigger;

	// sequencing group
	pds_pkg::pds_state_type state;
	pds_pkg::pds_state_type next_state;
	logic [TIME_W-1:0]      timer;
	logic [TIME_W-1:0]      next_timer;
	logic [TIME_W-1:0]      time_limit;
	logic                   time_up;
	logic [CYCLE_W-1:0]     cycles;
	logic [CYCLE_W-1:0]     next_cycles;
	logic                   last_cycle;
	logic                   to_forward;
	logic                   next_to_forward;

	// output group
	logic                   next_override;
	logic                   next_ramp_stop;
	logic                   next_run;
	logic                   next_reverse;
	logic [SPEED_W-1:0]     next_speed;
	logic                   next_active;
	logic                   next_digital_output;
	logic [STATUS_W-1:0]    next_ext_status;

	// start and stop commands share one selection decode
	function automatic logic select_allows(
		input logic [1:0] sel,
		input logic [1:0] want
	);
		select_allows = (sel == want) || (sel == pds_pkg::SEL_BOTH);
	endfunction

	// pulse states drive the motor, all others leave it undriven
	function automatic logic pulse_state(
		input pds_pkg::pds_state_type s
	);
		pulse_state = (s == pds_pkg::PDS_REVERSE) || (s == pds_pkg::PDS_FORWARD);
	endfunction

	// pulse widths are whole ticks; the first tick of a phase may be short
	pds_tick #(
		.TICKS(TICKS)
	) u_tick (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.o_tick (tick)
	);

	// power trigger acts on the rising edge only, so a pump that stays
	// heavy after an event does not start the next one at once
	always_comb begin
		next_over_limit = i_power_trigger_enable && (i_power > i_power_limit);
		power_rise      = next_over_limit && !over_limit;
		command_hit     = 1'b0;
		if (i_start_cmd && select_allows(i_start_stop_select, pds_pkg::SEL_START)) begin
			command_hit = 1'b1;
		end
		if (i_stop_cmd && select_allows(i_start_stop_select, pds_pkg::SEL_STOP)) begin
			command_hit = 1'b1;
		end
		// a zero cycle count would be an event with nothing to do
		trigger = 1'b0;
		if (i_enable && (i_cycle_count != '0)) begin
			trigger = command_hit
				|| i_digital_input
				|| i_sequence_logic_controller
				|| i_timed_action
				|| power_rise;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			over_limit <= 1'b0;
		end else begin
			over_limit <= next_over_limit;
		end
	end

	// pulses last the run time, delays and coasts the off delay
	assign time_limit = pulse_state(state) ? i_run_time : i_off_delay;
	assign time_up    = (timer >= time_limit);
	assign last_cycle = ((cycles + CYCLE_W'(1)) >= i_cycle_count);

	// timer saturates at its limit, so a late tick cannot wrap it
	always_comb begin
		next_state      = state;
		next_timer      = timer;
		next_cycles     = cycles;
		next_to_forward = to_forward;
		if (tick && !time_up) begin
			next_timer = timer + TIME_W'(1);
		end
		case (state)
			pds_pkg::PDS_IDLE: begin
				next_timer = '0;
				// triggers during an event are ignored, not queued
				if (trigger) begin
					next_cycles     = '0;
					next_to_forward = 1'b0;
					if (i_motor_stopped) begin
						next_state = pds_pkg::PDS_REVERSE;
					end else begin
						next_state = pds_pkg::PDS_RAMPDOWN;
					end
				end
			end
			pds_pkg::PDS_RAMPDOWN: begin
				// no time limit here: the drive's own ramp decides how long
				next_timer = '0;
				if (i_motor_stopped) begin
					next_state = pds_pkg::PDS_PREDELAY;
				end
			end
			pds_pkg::PDS_PREDELAY: begin
				if (time_up) begin
					next_state = pds_pkg::PDS_REVERSE;
					next_timer = '0;
				end
			end
			pds_pkg::PDS_REVERSE: begin
				if (time_up) begin
					next_state      = pds_pkg::PDS_COAST;
					next_timer      = '0;
					next_to_forward = 1'b1;
				end
			end
			pds_pkg::PDS_COAST: begin
				// one coast state serves both gaps, to_forward picks the way out
				if (time_up) begin
					next_timer = '0;
					if (to_forward) begin
						next_state = pds_pkg::PDS_FORWARD;
					end else begin
						next_state = pds_pkg::PDS_REVERSE;
					end
				end
			end
			pds_pkg::PDS_FORWARD: begin
				if (time_up) begin
					next_timer  = '0;
					next_cycles = cycles + CYCLE_W'(1);
					if (last_cycle) begin
						next_state = pds_pkg::PDS_IDLE;
					end else begin
						next_state      = pds_pkg::PDS_COAST;
						next_to_forward = 1'b0;
					end
				end
			end
			default: begin
				next_state = pds_pkg::PDS_IDLE;
				next_timer = '0;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state      <= pds_pkg::PDS_IDLE;
			timer      <= '0;
			cycles     <= '0;
			to_forward <= 1'b0;
		end else begin
			state      <= next_state;
			timer      <= next_timer;
			cycles     <= next_cycles;
			to_forward <= next_to_forward;
		end
	end

	// outputs follow the next state so they line up with it, not a cycle late
	always_comb begin
		next_active         = (next_state != pds_pkg::PDS_IDLE);
		next_override       = next_active;
		next_ramp_stop      = (next_state == pds_pkg::PDS_RAMPDOWN);
		next_run            = pulse_state(next_state);
		next_reverse        = (next_state == pds_pkg::PDS_REVERSE);
		next_speed          = SPEED_W'(pds_pkg::SPEED_RESET);
		if (next_run) begin
			next_speed = i_derag_speed;
		end
		next_digital_output = next_active && i_output_assigned;
	end

	// only the deragging bit of the extended status word belongs to this block
	genvar bit_index;
	generate
		for (bit_index = 0; bit_index < STATUS_W; bit_index++) begin : g_status
			if (bit_index == pds_pkg::DERAG_BIT) begin : g_derag
				assign next_ext_status[bit_index] = next_active;
			end else begin : g_other
				assign next_ext_status[bit_index] = 1'b0;
			end
		end
	endgenerate

	// motor commands
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_override  <= 1'b0;
			o_ramp_stop <= 1'b0;
			o_run       <= 1'b0;
			o_reverse   <= 1'b0;
			o_speed     <= SPEED_W'(pds_pkg::SPEED_RESET);
		end else begin
			o_override  <= next_override;
			o_ramp_stop <= next_ramp_stop;
			o_run       <= next_run;
			o_reverse   <= next_reverse;
			o_speed     <= next_speed;
		end
	end

	// status; the cycle count keeps its last value after the event
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_active         <= 1'b0;
			o_digital_output <= 1'b0;
			o_ext_status     <= '0;
			o_cycles_done    <= '0;
		end else begin
			o_active         <= next_active;
			o_digital_output <= next_digital_output;
			o_ext_status     <= next_ext_status;
			o_cycles_done    <= next_cycles;
		end
	end
endmodule // pds_sequencer

// ### sim/pds_props.sv
/* pds_props: assertions on the deragging sequencer ports.
 assumes it is bound to every pds_sequencer instance. */
`timescale 1ns/1ps
module pds_props (
	input wire logic        i_clock, i_rst_n, i_motor_stopped, i_output_assigned,
	input wire logic [7:0]  i_cycle_count, o_cycles_done,
	input wire logic [15:0] i_derag_speed, o_speed,
	input wire logic        o_ramp_stop, o_run, o_reverse, o_active, o_digital_output,
	input wire logic [31:0] o_ext_status
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	status_bit_a: assert property (o_ext_status[23] == o_active) else $error("status bit");
	dout_mirror_a: assert property (i_output_assigned |-> o_digital_output == o_active) else $error("dout");
	derag_speed_a: assert property (o_run |-> o_speed == i_derag_speed) else $error("speed");
	ramp_no_run_a: assert property (o_ramp_stop |-> !o_run) else $error("ramp");
	skip_delay_a: assert property ($rose(o_active) && i_motor_stopped |-> !o_ramp_stop) else $error("skip");
	coast_gap_a: assert property (o_run && o_reverse |=> !o_run || o_reverse) else $error("coast");
	count_bound_a: assert property (o_cycles_done <= i_cycle_count) else $error("count");
	idle_no_run_a: assert property (!o_active |-> !o_run) else $error("idle run");
	ramp_hold_a: assert property (o_ramp_stop && !i_motor_stopped |=> o_ramp_stop) else $error("ramp hold");
	dout_off_a: assert property (!i_output_assigned |-> !o_digital_output) else $error("dout off");
	cover property ($fell(o_active));
	cover property (o_run && o_reverse);
	cover property ($rose(o_ramp_stop));
endmodule // pds_props
bind pds_sequencer pds_props u_props (.*);

// ### sim/pds_motor_model.sv
/* pds_motor_model: drive speed loop seen from the sequencer.
 assumes run commands from the sequencer; spin models normal running. */
`timescale 1ns/1ps
module pds_motor_model (
	input wire logic i_clock, i_rst_n, i_spin, i_override, i_run,
	output logic     o_stopped
);
	logic [2:0] idle;
	// standstill only after five undriven cycles, so ramp down takes time
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) idle <= 3'h5;
		else if (i_run || (i_spin && !i_override)) idle <= 3'h0;
		else if (idle != 3'h5) idle <= idle + 3'h1;
	end
	assign o_stopped = (idle == 3'h5);
endmodule // pds_motor_model

// ### sim/pump_derag_sequencer_tb_top.sv
/* pump_derag_sequencer_tb_top: event tests through each trigger.
 assumes triggers are one-cycle pulses; tick shortened to 4 clocks. */
`timescale 1ns/1ps
module pump_derag_sequencer_tb_top;
	logic i_clock = 0, i_rst_n = 0, spin = 0, stopped, ov, rs, run, rev, act, dout;
	logic [1:0] sel = pds_pkg::SEL_START;
	logic [5:0] trig = 6'h00;
	logic [15:0] spd;
	logic [31:0] st;
	logic [7:0] done, cnt = 8'h02;
	logic asg = 1, pen = 1, prev_rr = 0;
	int err_count = 0, compares = 0, cyc = 0, revs = 0;
	always #5 i_clock = ~i_clock;
	always @(posedge i_clock) begin
		cyc++;
		if (run && rev && !prev_rr) revs++;
		prev_rr = run && rev;
		if (cyc == 20000) begin err_count++; end_sim(); end
	end
	pds_sequencer #(.TICKS(4)) u_dut (.i_clock, .i_rst_n, .i_enable(1'b1),
		.i_start_stop_select(sel), .i_cycle_count(cnt), .i_off_delay(16'h0002),
		.i_run_time(16'h0003), .i_derag_speed(16'h0123), .i_output_assigned(asg),
		.i_power_trigger_enable(pen), .i_power_limit(16'h0100), .i_start_cmd(trig[0]),
		.i_stop_cmd(trig[1]), .i_digital_input(trig[2]), .i_sequence_logic_controller(trig[3]),
		.i_timed_action(trig[4]), .i_power({16{trig[5]}}), .i_motor_stopped(stopped),
		.o_override(ov), .o_ramp_stop(rs), .o_run(run), .o_reverse(rev), .o_speed(spd),
		.o_active(act), .o_digital_output(dout), .o_ext_status(st), .o_cycles_done(done));
	pds_motor_model u_motor (.i_clock, .i_rst_n, .i_spin(spin), .i_override(ov), .i_run(run),
		.o_stopped(stopped));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin err_count++; $display("[ERR] %0t seen %h exp %h", $time, seen, exp); end
	endtask
	task ev(input int k, input logic exp);
		revs = 0;
		@(posedge i_clock) #1 trig[k] = 1;
		@(posedge i_clock) #1 trig[k] = 0;
		repeat (40) if (act !== 1'b1) begin @(posedge i_clock); #1; end
		chk(act, exp);
		if (exp) begin
			chk(st, pds_pkg::DERAG_MASK);
			chk(dout, asg);
			repeat (3000) if (act !== 1'b0) begin @(posedge i_clock); #1; end
			chk(act, 1'b0);
			chk(st, 32'h0);
			chk(done, cnt);
			chk(revs, cnt);
		end
	endtask
	task end_sim;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge i_clock);
		#1 i_rst_n = 1;
		ev(0, 1);
		ev(1, 0);
		sel = pds_pkg::SEL_STOP;
		ev(0, 0);
		ev(1, 1);
		sel = pds_pkg::SEL_BOTH;
		ev(0, 1);
		sel = pds_pkg::SEL_OFF;
		ev(1, 0);
		asg = 0;
		for (int k = 2; k < 5; k++) ev(k, 1);
		asg = 1;
		spin = 1;
		ev(5, 1);
		pen = 0;
		ev(5, 0);
		cnt = 8'h03;
		ev(2, 1);
		end_sim();
	end
endmodule // pump_derag_sequencer_tb_top
